// file: hdl/tsr_pkg.sv
// Shared constants and types of the temperature sensor register block
package tsr_pkg;

  localparam int TSR_W = 16;
  localparam int TSR_CMD_W = 8;

  // Command byte fields
  localparam int CMD_RW_BIT = 7;
  localparam int CMD_ZERO_HI = 6;
  localparam int CMD_ZERO_LO = 3;
  localparam int CMD_SEL_HI = 2;
  localparam logic [3:0] CMD_ZERO_FIELD = 4'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Register select codes
  localparam logic [2:0] SEL_CODE_TEMP = 3'h0;
  localparam logic [2:0] SEL_CODE_CTRL = 3'h1;
  localparam logic [2:0] SEL_CODE_HIGH = 3'h2;
  localparam logic [2:0] SEL_CODE_LOW = 3'h3;
  localparam logic [2:0] SEL_CODE_ID = 3'h7;

  // Control/status and temperature bit positions
  localparam int CS_SHUTDOWN = 15;
  localparam int CS_ONESHOT = 14;
  localparam int CS_ALRM_RST = 13;
  localparam int CS_TOGGLE = 12;
  localparam int CS_ALRM_STAT = 11;
  localparam int CS_HI = 10;
  localparam int CS_LO = 9;
  localparam int CS_DONE_FLAG = 8;
  localparam int CS_DIS = 7;
  localparam int CS_POL = 6;
  localparam int CS_RES_HI = 5;
  localparam int CS_RES_LO = 4;
  localparam int CS_RSV_HI = 2;
  localparam int CS_RSV_LO = 1;
  localparam int TEMP_TOGGLE_BIT = 0;
  localparam int TEMP_LSB_HI = 1;

  // Reset and fixed values
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] HIGH_RESET = 16'h4880;
  localparam logic [15:0] LOW_RESET = 16'h4600;
  localparam logic [15:0] LIMIT_MASK = 16'hFFE0;
  localparam logic [15:0] ONESHOT_TEMP = 16'h8000;
  localparam logic [1:0] RES_RESET = 2'h0;
  localparam logic [1:0] RSV_RESET = 2'h0;
  localparam logic PIN_RESET = 1'b1;

  // Resolution codes and the data bits each keeps
  localparam logic [1:0] RES_13 = 2'h0;
  localparam logic [1:0] RES_14 = 2'h1;
  localparam logic [1:0] RES_15 = 2'h2;
  localparam logic [1:0] RES_16 = 2'h3;
  localparam logic [15:0] MASK_13 = 16'hFFF8;
  localparam logic [15:0] MASK_14 = 16'hFFFC;
  localparam logic [15:0] MASK_15 = 16'hFFFE;
  localparam logic [15:0] MASK_16 = 16'hFFFF;

  typedef enum logic [2:0] {
    SEL_TEMP,
    SEL_CTRL,
    SEL_HIGH,
    SEL_LOW,
    SEL_ID,
    SEL_BAD
  } tsr_sel_t;

endpackage

// file: hdl/tsr_eval_if.sv
// Connection between register logic and limit evaluator
`timescale 1ns/1ps
`default_nettype none
interface tsr_eval_if;
  logic eval;
  logic [15:0] temp;
  logic [15:0] high_lim;
  logic [15:0] low_lim;
  logic alarm_clr;
  logic stat_rd;
  logic alarm;
  logic hi_flag;
  logic lo_flag;

  modport regs (
    output eval,
    output temp,
    output high_lim,
    output low_lim,
    output alarm_clr,
    output stat_rd,
    input alarm,
    input hi_flag,
    input lo_flag
  );

  modport evaluator (
    input eval,
    input temp,
    input high_lim,
    input low_lim,
    input alarm_clr,
    input stat_rd,
    output alarm,
    output hi_flag,
    output lo_flag
  );
endinterface
`default_nettype wire

// file: hdl/tsr_limit_eval.sv
// Limit comparison, limit flags and alarm latch
`timescale 1ns/1ps
`default_nettype none
module tsr_limit_eval
  import tsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  tsr_eval_if.evaluator ev
);

  typedef struct packed {
    logic alarm;
    logic hi_flag;
    logic lo_flag;
    logic hi_now;
    logic lo_now;
  } tsr_eval_state_t;

  tsr_eval_state_t st_reg;
  tsr_eval_state_t st_next;
  logic above;
  logic below;

  // Signed compare against the stored result
  assign above = $signed(ev.temp) > $signed(ev.high_lim);
  assign below = $signed(ev.temp) < $signed(ev.low_lim);

  always_comb begin
    st_next = st_reg;
    if (ev.eval) begin
      st_next.hi_now = above;
      st_next.lo_now = below;
    end
    // Flags clear on a status read once the condition is gone; a new event wins
    st_next.hi_flag = (ev.eval & above) | (st_reg.hi_flag & ~(ev.stat_rd & ~st_reg.hi_now));
    st_next.lo_flag = (ev.eval & below) | (st_reg.lo_flag & ~(ev.stat_rd & ~st_reg.lo_now));
    // Alarm asserts above the upper limit, clears on reset write or below lower limit
    st_next.alarm = (ev.eval & above) | (st_reg.alarm & ~(ev.alarm_clr | (ev.eval & below)));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign ev.alarm = st_reg.alarm;
  assign ev.hi_flag = st_reg.hi_flag;
  assign ev.lo_flag = st_reg.lo_flag;

endmodule
`default_nettype wire

// file: hdl/tsr_reg_top.sv
// Register bank of the serial temperature sensor
// Behaviour
// - After an illegal command byte, the next read returns zero.
// - Select 0 temperature, 1 control, 2 upper, 3 lower, 7 identification; others read zero, ignore writes.
// - Pointer resets to zero, selecting the temperature register first.
// - All registers stay reachable in shutdown; temperature keeps last completed result.
// - Temperature bits 15..1 hold latest result, two's complement, valid after first done.
// - Temperature bits below the selected resolution read zero, except bit 0 outside 16-bit mode.
// - Bit 0 toggles on temperature read after a new conversion, except 16-bit mode.
// - Starting a single conversion loads 8000h into temperature until the result.
// - Control bit 15 selects shutdown; zero returns to continuous conversion.
// - Bit 14 write starts one conversion only in shutdown; reads zero.
// - Bit 13 write clears alarm status and pin; reads zero.
// - Control bit 12 toggles on control read after a new conversion.
// - Bit 11 mirrors alarm; clears on reset write or below lower limit.
// - Bit 10 sets above upper limit; clears on control read once back below.
// - Bit 9 sets below lower limit; clears on control read once back above.
// - Bit 8 is data available: cleared by control read, set when a conversion finishes.
// - Bit 7 disables the alarm pin and its status bit.
// - Bit 6 sets alarm polarity, one active high, zero active low.
// - Control register read with command 81h, written with 01h.
// - Bits 5..4 select 13, 14, 15 or 16 bit resolution.
// - Upper limit uses 82h/02h, lower limit 83h/03h.
// - Alarm and upper flag set when stored result exceeds the upper limit.
`timescale 1ns/1ps
`default_nettype none
module tsr_reg_top
  import tsr_pkg::*;
#(
  // Arbitrary neutral identification value
  parameter logic [15:0] ID_VALUE = 16'hA5C3
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic CMD_WR,
  input wire logic [tsr_pkg::TSR_CMD_W-1:0] CMD_BYTE,
  input wire logic REG_WR,
  input wire logic [tsr_pkg::TSR_W-1:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [tsr_pkg::TSR_W-1:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic CONV_DONE,
  input wire logic [tsr_pkg::TSR_W-1:0] CONV_DATA,
  output logic CONV_RUN,
  output logic ALARM_PIN
);
  import tsr_pkg::*;

  typedef struct packed {
    logic [7:0] ptr;
    logic shutdown_request_bit;
    logic alarm_dis;
    logic alarm_pol;
    logic resolution_select_high;
    logic resolution_select_low;
    logic [1:0] rsv;
    logic [15:0] high_lim;
    logic [15:0] low_lim;
    logic [15:0] temp;
    logic temp_tgl;
    logic ctrl_tgl;
    logic temp_pend;
    logic ctrl_pend;
    logic conversion_done_flag;
    logic oneshot;
    logic [15:0] rdata;
    logic rvalid;
    logic conv_run;
    logic pin;
  } tsr_top_state_t;

  tsr_top_state_t st_reg;
  tsr_top_state_t st_next;
  tsr_sel_t sel;
  logic [1:0] res;
  logic [15:0] res_mask;
  logic [15:0] done_temp;
  logic [15:0] ctrl_word;
  logic over_limit_alarm;
  logic wr_ok;
  logic alarm_clr;
  logic stat_rd;

  tsr_eval_if ev ();

  tsr_limit_eval u_eval (
    .clk(MCLK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .ev(ev)
  );

  // Pointer decode; nonzero unused bits make the pointer illegal
  always_comb begin
    if (st_reg.ptr[CMD_ZERO_HI:CMD_ZERO_LO] != CMD_ZERO_FIELD) begin
      sel = SEL_BAD;
    end else begin
      case (st_reg.ptr[CMD_SEL_HI:0])
        SEL_CODE_TEMP: sel = SEL_TEMP;
        SEL_CODE_CTRL: sel = SEL_CTRL;
        SEL_CODE_HIGH: sel = SEL_HIGH;
        SEL_CODE_LOW: sel = SEL_LOW;
        SEL_CODE_ID: sel = SEL_ID;
        default: sel = SEL_BAD;
      endcase
    end
  end

  // Resolution mask
  assign res = {st_reg.resolution_select_high, st_reg.resolution_select_low};
  always_comb begin
    case (res)
      RES_13: res_mask = MASK_13;
      RES_14: res_mask = MASK_14;
      RES_15: res_mask = MASK_15;
      RES_16: res_mask = MASK_16;
      default: res_mask = MASK_13;
    endcase
  end

  assign done_temp = CONV_DATA & res_mask;

  // Alarm status follows the pin, so the disable gates it too
  assign over_limit_alarm = ev.alarm & ~st_reg.alarm_dis;

  // Control word as read; one-shot and alarm reset read zero
  always_comb begin
    ctrl_word = ZERO_WORD;
    ctrl_word[CS_SHUTDOWN] = st_reg.shutdown_request_bit;
    ctrl_word[CS_TOGGLE] = st_reg.ctrl_tgl ^ st_reg.ctrl_pend;
    ctrl_word[CS_ALRM_STAT] = over_limit_alarm;
    ctrl_word[CS_HI] = ev.hi_flag;
    ctrl_word[CS_LO] = ev.lo_flag;
    ctrl_word[CS_DONE_FLAG] = st_reg.conversion_done_flag;
    ctrl_word[CS_DIS] = st_reg.alarm_dis;
    ctrl_word[CS_POL] = st_reg.alarm_pol;
    ctrl_word[CS_RES_HI] = st_reg.resolution_select_high;
    ctrl_word[CS_RES_LO] = st_reg.resolution_select_low;
    ctrl_word[CS_RSV_HI:CS_RSV_LO] = st_reg.rsv;
  end

  // Writes need the write direction in the pointer
  assign wr_ok = REG_WR & ~st_reg.ptr[CMD_RW_BIT];
  assign alarm_clr = wr_ok & (sel == SEL_CTRL) & REG_WDATA[CS_ALRM_RST];
  assign stat_rd = REG_RD & (sel == SEL_CTRL);

  assign ev.eval = CONV_DONE;
  assign ev.temp = done_temp;
  assign ev.high_lim = st_reg.high_lim;
  assign ev.low_lim = st_reg.low_lim;
  assign ev.alarm_clr = alarm_clr;
  assign ev.stat_rd = stat_rd;

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;

    // Conversion result: stored in shutdown or not, marks news for both toggles
    if (CONV_DONE) begin
      st_next.temp = done_temp;
      st_next.oneshot = 1'b0;
    end

    // Read access; pending news is consumed unless a new result arrives now
    if (REG_RD) begin
      st_next.rvalid = 1'b1;
      case (sel)
        SEL_TEMP: begin
          st_next.temp_tgl = st_reg.temp_tgl ^ st_reg.temp_pend;
          if (res == RES_16) begin
            st_next.rdata = st_reg.temp & res_mask;
          end else begin
            st_next.rdata = st_reg.temp & res_mask;
            st_next.rdata[TEMP_TOGGLE_BIT] = st_reg.temp_tgl ^ st_reg.temp_pend;
          end
        end
        SEL_CTRL: begin
          st_next.ctrl_tgl = st_reg.ctrl_tgl ^ st_reg.ctrl_pend;
          st_next.rdata = ctrl_word;
        end
        SEL_HIGH: st_next.rdata = st_reg.high_lim;
        SEL_LOW: st_next.rdata = st_reg.low_lim;
        SEL_ID: st_next.rdata = ID_VALUE;
        SEL_BAD: st_next.rdata = ZERO_WORD;
        default: st_next.rdata = ZERO_WORD;
      endcase
    end

    // News flags: a conversion finishing in the read cycle wins
    st_next.temp_pend = CONV_DONE | (st_reg.temp_pend & ~(REG_RD & (sel == SEL_TEMP)));
    st_next.ctrl_pend = CONV_DONE | (st_reg.ctrl_pend & ~stat_rd);
    st_next.conversion_done_flag = CONV_DONE | (st_reg.conversion_done_flag & ~stat_rd);

    // Write access; illegal pointers change nothing
    if (wr_ok) begin
      case (sel)
        SEL_CTRL: begin
          st_next.shutdown_request_bit = REG_WDATA[CS_SHUTDOWN];
          st_next.alarm_dis = REG_WDATA[CS_DIS];
          st_next.alarm_pol = REG_WDATA[CS_POL];
          st_next.resolution_select_high = REG_WDATA[CS_RES_HI];
          st_next.resolution_select_low = REG_WDATA[CS_RES_LO];
          st_next.rsv = REG_WDATA[CS_RSV_HI:CS_RSV_LO];
          // Single conversion only from shutdown
          if (REG_WDATA[CS_ONESHOT] && st_reg.shutdown_request_bit && !st_reg.oneshot) begin
            st_next.oneshot = 1'b1;
            st_next.temp = ONESHOT_TEMP;
            st_next.conversion_done_flag = 1'b0;
          end
        end
        SEL_HIGH: st_next.high_lim = REG_WDATA & LIMIT_MASK;
        SEL_LOW: st_next.low_lim = REG_WDATA & LIMIT_MASK;
        default: st_next.high_lim = st_reg.high_lim;
      endcase
    end

    // Command byte loads the pointer; an access in the same cycle used the old one
    if (CMD_WR) begin
      st_next.ptr = CMD_BYTE;
    end

    // Converter runs continuously unless shut down, and also while a single conversion is owed
    st_next.conv_run = ~st_next.shutdown_request_bit | st_next.oneshot;

    // Pin drive with polarity; disabled pin rests at the inactive level
    st_next.pin = over_limit_alarm ? st_reg.alarm_pol : ~st_reg.alarm_pol;
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
      st_reg.ptr <= PTR_RESET;
      st_reg.resolution_select_high <= RES_RESET[1];
      st_reg.resolution_select_low <= RES_RESET[0];
      st_reg.rsv <= RSV_RESET;
      st_reg.high_lim <= HIGH_RESET;
      st_reg.low_lim <= LOW_RESET;
      st_reg.temp <= ZERO_WORD;
      st_reg.rdata <= ZERO_WORD;
      st_reg.conv_run <= 1'b1;
      st_reg.pin <= PIN_RESET;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA = st_reg.rdata;
  assign REG_RVALID = st_reg.rvalid;
  assign CONV_RUN = st_reg.conv_run;
  assign ALARM_PIN = st_reg.pin;

endmodule
`default_nettype wire

// file: tb/tsr_conv_model.sv
// Converter stand-in that answers the register block
`timescale 1ns/1ps
`default_nettype none
module tsr_conv_model (
  input wire logic clk,
  input wire logic run,
  input wire logic fire,
  input wire logic [15:0] value,
  output logic done,
  output logic [15:0] data
);
  initial done = 1'b0;
  initial data = 16'h0000;
  // Result only while running; otherwise data keeps changing
  always @(posedge clk) begin
    done <= fire && run;
    data <= (fire && run) ? value : ~data;
  end
endmodule
`default_nettype wire

// file: tb/tsr_reg_props.sv
// Port-level assertions of the register block
`timescale 1ns/1ps
`default_nettype none
module tsr_reg_props (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic CONV_DONE,
  input wire logic CONV_RUN,
  input wire logic ALARM_PIN
);
  wire logic ev = (REG_WR || CONV_DONE) && CLK_EN;
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence rd_taken;
    REG_RD && CLK_EN;
  endsequence
  sequence caused;
    $past(ev) || $past(ev, 2) || $past(ev, 3);
  endsequence
  read_answer_a: assert property (rd_taken |=> REG_RVALID)
    else $error("read not answered");
  no_stray_a: assert property (CLK_EN && !REG_RD |=> !REG_RVALID)
    else $error("valid without read");
  valid_once_a: assert property (rd_taken ##1 (CLK_EN && !REG_RD) |=> !REG_RVALID)
    else $error("valid too long");
  data_holds_a: assert property (!REG_RVALID && !$past(SYS_RST) |-> $stable(REG_RDATA))
    else $error("read data moved");
  reset_state_a: assert property (disable iff (1'b0)
      SYS_RST |=> REG_RDATA == 16'h0000 && !REG_RVALID && CONV_RUN && ALARM_PIN)
    else $error("bad reset state");
  run_cause_a: assert property ($changed(CONV_RUN) && !$past(SYS_RST) |-> caused)
    else $error("run moved alone");
  pin_cause_a: assert property ($changed(ALARM_PIN) && !$past(SYS_RST) |-> caused)
    else $error("pin moved alone");
  clock_freeze_a: assert property (!CLK_EN |=> $stable(CONV_RUN) && $stable(ALARM_PIN))
    else $error("state moved while frozen");
endmodule
bind tsr_reg_top tsr_reg_props u_tsr_reg_props (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .CLK_EN(CLK_EN), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .CONV_DONE(CONV_DONE), .CONV_RUN(CONV_RUN), .ALARM_PIN(ALARM_PIN));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the temperature sensor register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tsr_pkg::*;
  localparam logic [15:0] ID_V = 16'h5A3C; // Arbitrary value
  logic mclk = 0, sys_rst = 1, clk_en = 1, cmd_wr = 0, reg_wr = 0, reg_rd = 0, fire = 0;
  logic [7:0] cmd_byte = 8'h00;
  logic [15:0] wdata = 16'h0000, fval = 16'h0000, rdata, cdata, got, d;
  logic rvalid, cdone, crun, pin;
  logic [15:0] ctl = 0, hil = 16'h4880, lol = 16'h4600, tmp = 0;
  logic ttog = 0, tpd = 0, ctog = 0, cpd = 0, dflag = 0, alm = 0, hif = 0, lof = 0;
  logic abv = 0, blw = 0, osp = 0;
  logic [7:0] bad [6] = '{8'h84, 8'h85, 8'h86, 8'h89, 8'hC1, 8'hF7};
  logic [7:0] wbad [5] = '{8'h09, 8'h04, 8'h07, 8'h81, 8'h82};
  int mismatches = 0, num_checks = 0, seed = 54106, i;
  always #12.5 mclk = ~mclk;
  tsr_reg_top #(.ID_VALUE(ID_V)) u_tsr_reg_top (.MCLK(mclk), .SYS_RST(sys_rst),
    .CLK_EN(clk_en), .CMD_WR(cmd_wr), .CMD_BYTE(cmd_byte), .REG_WR(reg_wr),
    .REG_WDATA(wdata), .REG_RD(reg_rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .CONV_DONE(cdone), .CONV_DATA(cdata), .CONV_RUN(crun), .ALARM_PIN(pin));
  tsr_conv_model u_tsr_conv_model (.clk(mclk), .run(crun), .fire(fire), .value(fval),
    .done(cdone), .data(cdata));
  function automatic logic [15:0] msk(input logic [1:0] r);
    return r == 0 ? MASK_13 : r == 1 ? MASK_14 : r == 2 ? MASK_15 : MASK_16;
  endfunction
  function automatic logic [15:0] cexp();
    return {ctl[15], 2'b00, ctog, alm & ~ctl[7], hif, lof, dflag, ctl[7:0]};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    cmd_wr <= 1'b1;
    cmd_byte <= b;
    @(posedge mclk);
    cmd_wr <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] v);
    reg_wr <= 1'b1;
    wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(output logic [15:0] v);
    int k;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    for (k = 0; k < 4 && rvalid !== 1'b1; k++) begin
      @(posedge mclk);
    end
    if (k == 4) begin
      mismatches++;
      stop_test();
    end
    v = rdata;
  endtask
  task automatic acc(input logic [7:0] c, input logic [15:0] e);
    cmd(c);
    rd(got);
    chk("register", e, got);
  endtask
  task automatic lim(input logic [7:0] c, input logic [15:0] v);
    cmd(c);
    wr(v);
    acc(c | 8'h80, v & 16'hFFE0);
  endtask
  task automatic rtemp();
    cmd(8'h80);
    rd(got);
    if (tpd) ttog = ~ttog;
    tpd = 0;
    chk("temp", ctl[5:4] == 2'h3 ? tmp : (tmp & msk(ctl[5:4])) | ttog, got);
  endtask
  task automatic rctl();
    cmd(8'h81);
    rd(got);
    if (cpd) ctog = ~ctog;
    cpd = 0;
    chk("control", cexp(), got);
    dflag = 0;
    if (!abv) hif = 0;
    if (!blw) lof = 0;
    chk("pin", {15'h0000, (alm & ~ctl[7]) ? ctl[6] : !ctl[6]}, {15'h0000, pin});
  endtask
  task automatic wctl(input logic [15:0] v);
    cmd(8'h01);
    wr(v);
    if (v[14] && ctl[15] && !osp) begin
      osp = 1;
      tmp = 16'h8000;
      dflag = 0;
    end
    if (v[13]) alm = 0;
    ctl = v & 16'h80F6;
    repeat (2) @(posedge mclk);
    chk("run", !ctl[15] || osp, crun);
  endtask
  task automatic conv(input logic [15:0] v);
    fire <= 1'b1;
    fval <= v;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (2) @(posedge mclk);
    if (!ctl[15] || osp) begin
      tmp = v & msk(ctl[5:4]);
      dflag = 1;
      tpd = 1;
      cpd = 1;
      osp = 0;
      abv = $signed(tmp) > $signed(hil);
      blw = $signed(tmp) < $signed(lol);
      hif |= abv; lof |= blw;
      alm = abv | (alm & ~blw);
    end
  endtask
  initial begin
    #(25 * 20000);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(got);
    chk("first read", 16'h0000, got);
    rctl();
    acc(8'h82, 16'h4880);
    acc(8'h83, 16'h4600);
    acc(8'h87, ID_V);
    foreach (bad[j]) acc(bad[j], 16'h0000);
    foreach (wbad[j]) begin cmd(wbad[j]); wr(16'hFFFF); end
    rctl();
    acc(8'h82, 16'h4880);
    $display("test access done");
    lim(8'h02, 16'($random(seed)));
    lim(8'h03, 16'($random(seed)));
    lim(8'h02, 16'h2000);
    lim(8'h03, 16'hE000);
    hil = 16'h2000;
    lol = 16'hE000;
    $display("test limits done");
    for (i = 0; i < 40; i++) begin
      d = 16'($random(seed)) & 16'hE0F6;
      d[5] = d[5] & ~d[4];
      wctl(d);
      conv(16'($random(seed)));
      rtemp();
      if (i % 3 == 0) rtemp();
      rctl();
      if (i % 4 == 0) rctl();
    end
    $display("test random done");
    clk_en <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk("frozen valid", 16'h0000, 16'(rvalid));
    clk_en <= 1'b1;
    wctl(16'h8030);
    conv(16'h1235);
    rtemp();
    wctl(16'hC030);
    rtemp();
    rctl();
    conv(16'h1235);
    rtemp();
    rctl();
    wctl(16'h0030);
    wctl(16'h4030);
    rtemp();
    $display("test single done");
    stop_test();
  end
endmodule
`default_nettype wire
